// File: logic/bit_defines.vh
`ifndef BIT_DEFINES_VH
`define BIT_DEFINES_VH
// ==========================================================
// Register addresses
`define BIT_ADDR_CONTROL     8'hd3
`define BIT_ADDR_COUNTER     8'hfd
// ==========================================================
// Control register reset value and fields
`define BIT_CONTROL_RESET    8'h00
`define BIT_WD_KEY_MSB       7
`define BIT_WD_KEY_LSB       4
`define BIT_WD_OFF_KEY       4'ha
`define BIT_SEL_MSB          3
`define BIT_SEL_LSB          2
`define BIT_CNT_CLR_BIT      1
`define BIT_DIV_CLR_BIT      0
// ==========================================================
// Tick select codes and divide ratios
`define BIT_SEL_DIV4096      2'h0
`define BIT_SEL_DIV1024      2'h1
`define BIT_SEL_DIV128       2'h2
`define BIT_DIV_WIDTH        12
`define BIT_DIV4096_TAP      11
`define BIT_DIV1024_TAP      9
`define BIT_DIV128_TAP       6
// ==========================================================
// Stabilization end bit of the counter
`define BIT_STAB_BIT         4
`endif

// File: logic/bit_prescaler.v
`timescale 1ns/1ps
`include "bit_defines.vh"
// ==========================================================
// Free-running divider producing one-cycle tick enables
module bit_prescaler #(
  parameter WIDTH    = `BIT_DIV_WIDTH,
  parameter SLOW_TAP = `BIT_DIV4096_TAP,
  parameter MID_TAP  = `BIT_DIV1024_TAP,
  parameter FAST_TAP = `BIT_DIV128_TAP
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       clear_i,
  input  wire       run_i,
  input  wire [1:0] sel_i,
  output wire       tick_o
);
  reg  [WIDTH-1:0] div_reg;
  wire [WIDTH-1:0] div_next;
  wire [WIDTH-1:0] carry;
  reg              tap;

  // Carry chain: carry k is set when bits k down to 0 are all one
  assign div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  genvar k;
  generate
    for (k = 0; k < WIDTH; k = k + 1) begin : g_carry
      assign carry[k] = &div_reg[k:0];
    end
  endgenerate

  // Divider clears on strobe; held while run is low
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      div_reg <= {WIDTH{1'b0}};
    end else if (run_i) begin
      div_reg <= div_next;
    end
  end

  // Tap select; unused code falls back to the slowest rate
  always @* begin
    case (sel_i)
      `BIT_SEL_DIV1024: tap = carry[MID_TAP];
      `BIT_SEL_DIV128:  tap = carry[FAST_TAP];
      default:          tap = carry[SLOW_TAP];
    endcase
  end

  assign tick_o = run_i & ~clear_i & tap;
endmodule // bit_prescaler

// File: logic/bit_counter.v
`timescale 1ns/1ps
`include "bit_defines.vh"
// ==========================================================
// 8-bit up-counter with wrap and bit-4 carry pulses
module bit_counter #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire             clear_i,
  input  wire             tick_i,
  output reg  [WIDTH-1:0] count_o,
  output wire             wrap_o,
  output wire             stab_o
);
  // Wrap from all ones is the carry out of the top bit
  assign wrap_o = tick_i & (&count_o);
  assign stab_o = tick_i & (&count_o[`BIT_STAB_BIT:0]);

  // Clear beats tick so a kick always restarts the interval
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= {WIDTH{1'b0}};
    end else if (clear_i) begin
      count_o <= {WIDTH{1'b0}};
    end else if (tick_i) begin
      count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // bit_counter

// File: logic/bit_watchdog.v
`timescale 1ns/1ps
`include "bit_defines.vh"
// ==========================================================
// Contract
// - Tick from divider: 4096, 1024 or 128
// - Read-only 8-bit counter at FDh
// - Read/write control register at D3h
// - Control resets to 00h: watchdog on, /4096
// - Watchdog off only with key 1010b
// - Any other key: overflow resets the chip
// - Control bit 1 clears counter
// - Control bit 0 clears divider
// - Enabled watchdog resets on each overflow; code resets only in run state, not during stabilization
// - Overflow is carry out of bit 7
// - After reset tick is CPU clock /4096
// - Stop wake: /4096 on reset, else preset
// - CPU clock gated until bit 4 carry
module bit_watchdog #(
  parameter DIV_WIDTH = `BIT_DIV_WIDTH,
  parameter SLOW_TAP  = `BIT_DIV4096_TAP,
  parameter MID_TAP   = `BIT_DIV1024_TAP,
  parameter FAST_TAP  = `BIT_DIV128_TAP
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire [7:0] addr_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  input  wire       stop_i,
  input  wire       wake_irq_i,
  output wire       cpu_clk_en_o,
  output wire       overflow_o,
  output reg        wdt_reset_o
);
  // ==========================================================
  // States of the oscillation stabilization sequencer
  localparam ST_STAB = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_STOP = 3'b100;

  reg  [7:0] ctrl_reg;
  reg  [7:0] ctrl_next;
  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg        force_slow_reg;
  reg        force_slow_next;
  reg        stop_s1_reg;
  reg        stop_s2_reg;
  reg        wake_s1_reg;
  reg        wake_s2_reg;
  wire       ctrl_wr;
  wire       cnt_clr;
  wire       div_clr;
  wire       wd_enabled;
  wire [1:0] sel_eff;
  wire       tick;
  wire       wrap;
  wire       stab;
  wire [7:0] count;
  wire       running;

  // ==========================================================
  // Register write decode
  assign ctrl_wr = wr_i & (addr_i == `BIT_ADDR_CONTROL);
  assign cnt_clr = ctrl_wr & wdata_i[`BIT_CNT_CLR_BIT];
  assign div_clr = ctrl_wr & wdata_i[`BIT_DIV_CLR_BIT];

  // Strobe bits are never stored, so they always read back zero
  always @* begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = {wdata_i[7:2], 2'b00};
    end
  end

  // Control register; reset value enables the watchdog at /4096
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= `BIT_CONTROL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================
  // Stop and wake requests come from other logic; synchronised anyway
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end else begin
      stop_s1_reg <= stop_i;
      stop_s2_reg <= stop_s1_reg;
      wake_s1_reg <= wake_irq_i;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  // ==========================================================
  // Sequencer: after reset the CPU waits for the bit 4 carry
  always @* begin
    state_next      = state_reg;
    force_slow_next = force_slow_reg;
    case (state_reg)
      ST_STAB: begin
        if (stab) begin
          state_next      = ST_RUN;
          force_slow_next = 1'b0;
        end
      end
      ST_RUN: begin
        if (stop_s2_reg) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        // Interrupt wake keeps the preset tick selection
        if (wake_s2_reg) begin
          state_next      = ST_STAB;
          force_slow_next = 1'b0;
        end
      end
      default: begin
        state_next      = ST_STAB;
        force_slow_next = 1'b1;
      end
    endcase
  end

  // Power-on reset enters stabilization at the slowest rate
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg      <= ST_STAB;
      force_slow_reg <= 1'b1;
    end else begin
      state_reg      <= state_next;
      force_slow_reg <= force_slow_next;
    end
  end

  assign running      = (state_reg != ST_STOP);
  assign cpu_clk_en_o = (state_reg == ST_RUN);
  assign sel_eff      = force_slow_reg ? `BIT_SEL_DIV4096 : ctrl_reg[`BIT_SEL_MSB:`BIT_SEL_LSB];

  // ==========================================================
  // Divider and counter
  // Taps are parameters so a short divider can stand in for the long one
  bit_prescaler #(
    .WIDTH    (DIV_WIDTH),
    .SLOW_TAP (SLOW_TAP),
    .MID_TAP  (MID_TAP),
    .FAST_TAP (FAST_TAP)
  ) i_bit_prescaler (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (div_clr),
    .run_i    (running),
    .sel_i    (sel_eff),
    .tick_o   (tick)
  );

  bit_counter #(
    .WIDTH    (8)
  ) i_bit_counter (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (cnt_clr),
    .tick_i   (tick),
    .count_o  (count),
    .wrap_o   (wrap),
    .stab_o   (stab)
  );

  assign overflow_o = wrap;

  // ==========================================================
  // Watchdog reset; the key test uses the stored upper nibble
  assign wd_enabled = (ctrl_reg[`BIT_WD_KEY_MSB:`BIT_WD_KEY_LSB] != `BIT_WD_OFF_KEY);

  // Registered one-cycle reset request; software must kick first
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= wrap & wd_enabled & (state_reg == ST_RUN);
    end
  end

  // ==========================================================
  // Registered read port; unmapped addresses read zero
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `BIT_ADDR_CONTROL: rdata_o <= ctrl_reg;
        `BIT_ADDR_COUNTER: rdata_o <= count;
        default:           rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // bit_watchdog

// File: test/bit_watchdog_sva.sv
`timescale 1ns/1ps
`include "bit_defines.vh"
// ==========================================================
// Port checker for the watchdog block
module bit_watchdog_sva (
  input wire       clk_i,
  input wire       resetn_i,
  input wire [7:0] addr_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire       stop_i,
  input wire       wake_irq_i,
  input wire       cpu_clk_en_o,
  input wire       overflow_o,
  input wire       wdt_reset_o
);
  reg  [7:0] ctrl_shadow_reg;
  wire       key_off;
  wire       ctrl_wr;
  // Mirror of the stored control bits; the strobes are never kept
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      ctrl_shadow_reg <= `BIT_CONTROL_RESET;
    else if (ctrl_wr)
      ctrl_shadow_reg <= wdata_i & 8'hfc;
  end
  assign ctrl_wr = wr_i && addr_i == `BIT_ADDR_CONTROL;
  assign key_off = ctrl_shadow_reg[7:4] == `BIT_WD_OFF_KEY;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_ovf_pulse; overflow_o |=> !overflow_o [*8]; endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
  property p_wdt_cause; wdt_reset_o |-> $past(overflow_o) && $past(cpu_clk_en_o); endproperty
  a_wdt_cause: assert property (p_wdt_cause) else $error("reset pulse without run overflow");
  property p_unmapped; rd_i && addr_i != `BIT_ADDR_CONTROL && addr_i != `BIT_ADDR_COUNTER |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_strobe_bits; rd_i && addr_i == `BIT_ADDR_CONTROL |=> rdata_o[1:0] == 2'h0; endproperty
  a_strobe_bits: assert property (p_strobe_bits) else $error("strobe bits read back");
  // Reading after a write, or untouched after reset, returns the stored bits
  property p_ctrl_rw; rd_i && addr_i == `BIT_ADDR_CONTROL && !ctrl_wr |=> rdata_o == $past(ctrl_shadow_reg);
  endproperty
  a_ctrl_rw: assert property (p_ctrl_rw) else $error("control readback wrong");
  property p_key_off; overflow_o && key_off |=> !wdt_reset_o; endproperty
  a_key_off: assert property (p_key_off) else $error("reset while disabled");
  property p_key_on; overflow_o && !key_off && cpu_clk_en_o && !ctrl_wr |=> wdt_reset_o; endproperty
  a_key_on: assert property (p_key_on) else $error("no reset on overflow");
  // Four held samples cover the two-flop sync plus the state update
  property p_stop_gate; stop_i [*4] |-> !cpu_clk_en_o; endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("CPU clock not gated in stop");
  c_ovf: cover property (overflow_o);
  c_wdt: cover property (wdt_reset_o);
  c_run: cover property ($rose(cpu_clk_en_o));
endmodule // bit_watchdog_sva

// File: test/bit_watchdog_tb.sv
`timescale 1ns/1ps
`include "bit_defines.vh"
// ==========================================================
// Self-checking bench for the watchdog block
module bit_watchdog_tb;
  reg        clk_i = 1'b0;
  reg        resetn_i = 1'b0;
  reg  [7:0] addr_i = 8'h00;
  reg        wr_i = 1'b0;
  reg        rd_i = 1'b0;
  reg  [7:0] wdata_i = 8'h00;
  reg        stop_i = 1'b0;
  reg        wake_irq_i = 1'b0;
  wire [7:0] rdata_o;
  wire       cpu_clk_en_o;
  wire       overflow_o;
  wire       wdt_reset_o;
  integer    fails = 0;
  integer    checked = 0;
  integer    cycles = 0;
  integer    n;
  integer    sel;
  integer    ratio;
  reg  [7:0] d;
  // Short divider keeps the run brief; the same tap logic sets every ratio
  localparam integer RATIO_SLOW = 128;
  localparam integer RATIO_MID  = 32;
  localparam integer RATIO_FAST = 8;
  bit_watchdog #(.DIV_WIDTH(7), .SLOW_TAP(6), .MID_TAP(4), .FAST_TAP(2)) i_bit_watchdog (.clk_i(clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .stop_i(stop_i), .wake_irq_i(wake_irq_i),
    .cpu_clk_en_o(cpu_clk_en_o), .overflow_o(overflow_o), .wdt_reset_o(wdt_reset_o));
  // ==========================================================
  // Helpers
  task tally_and_finish;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  // Strobe drops one cycle before the next access so it never toggles twice at once
  task wr(input [7:0] a, input [7:0] v);
    begin
      addr_i = a;
      wdata_i = v;
      wr_i = 1'b1;
      @(negedge clk_i);
      wr_i = 1'b0;
      @(negedge clk_i);
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clk_i);
      rd_i = 1'b0;
      v = rdata_o;
      @(negedge clk_i);
    end
  endtask
  // Bounded wait on overflow (1) or CPU clock enable (0)
  task wait_sig(input which, output integer k);
    begin
      k = 0;
      while (((which ? overflow_o : cpu_clk_en_o) !== 1'b1) && k < 10000) begin
        @(negedge clk_i);
        k = k + 1;
      end
    end
  endtask
  task in_range(input integer k, input integer lo, input integer hi);
    chk({7'h0, k >= lo && k <= hi}, 8'h01);
  endtask
  // ==========================================================
  // Clock and run-time ceiling
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    rd(`BIT_ADDR_CONTROL, d); chk(d, `BIT_CONTROL_RESET);
    rd(`BIT_ADDR_COUNTER, d); chk(d, 8'h00);
    rd(8'h10, d); chk(d, 8'h00);
    // 32 slow ticks from release, less the one idle cycle and six reading cycles
    wait_sig(1'b0, n); in_range(n, 32 * RATIO_SLOW - 11, 32 * RATIO_SLOW - 1);
    wr(`BIT_ADDR_CONTROL, 8'hab); rd(`BIT_ADDR_CONTROL, d); chk(d, 8'ha8);
    wr(`BIT_ADDR_COUNTER, 8'h55); rd(`BIT_ADDR_COUNTER, d); chk(d, 8'h00);
    // Every select code, three ticks after the divider clear; code 3 acts as the slow rate
    for (sel = 0; sel < 4; sel = sel + 1) begin
      ratio = (sel == 1) ? RATIO_MID : (sel == 2) ? RATIO_FAST : RATIO_SLOW;
      wr(`BIT_ADDR_CONTROL, {4'ha, sel[1:0], 2'b11});
      repeat (3 * ratio + ratio / 2 - 2) @(negedge clk_i);
      rd(`BIT_ADDR_COUNTER, d); chk(d, 8'h03);
    end
    // Disabling key: the wrap comes after 256 fast ticks but no reset
    wr(`BIT_ADDR_CONTROL, 8'hab); wait_sig(1'b1, n); in_range(n, 256 * RATIO_FAST - 8, 256 * RATIO_FAST + 4);
    @(negedge clk_i); chk({7'h0, wdt_reset_o}, 8'h00);
    // Stop, then interrupt wake at the preset fast rate
    wr(`BIT_ADDR_CONTROL, 8'hab);
    stop_i = 1'b1;
    repeat (8) @(negedge clk_i);
    chk({7'h0, cpu_clk_en_o}, 8'h00);
    stop_i = 1'b0;
    wake_irq_i = 1'b1;
    wait_sig(1'b0, n); in_range(n, 32 * RATIO_FAST - 6, 32 * RATIO_FAST + 6);
    wake_irq_i = 1'b0;
    // Armed key: a kick restarts the interval, then the wrap must reset the chip
    wr(`BIT_ADDR_CONTROL, 8'h0b);
    repeat (1500) @(negedge clk_i);
    wr(`BIT_ADDR_CONTROL, 8'h0b);
    wait_sig(1'b1, n); in_range(n, 256 * RATIO_FAST - 8, 256 * RATIO_FAST + 4);
    @(negedge clk_i); chk({7'h0, wdt_reset_o}, 8'h01);
    tally_and_finish;
  end
endmodule // bit_watchdog_tb
bind bit_watchdog bit_watchdog_sva i_bit_watchdog_sva (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .stop_i(stop_i), .wake_irq_i(wake_irq_i),
  .cpu_clk_en_o(cpu_clk_en_o), .overflow_o(overflow_o), .wdt_reset_o(wdt_reset_o));
